// File: hdl/hpc_config_bytes.sv
// Top of the hub power config bytes: seven bytes, mode selection, power-good delay.
// Assumes the loader (EEPROM or management port) writes one byte per strobe on SYS_CLK.
`timescale 1ns/1ps
`include "hpc_consts.svh"
module hpc_config_bytes #(
    parameter int unsigned PON_UNIT_CYC = `HPC_PON_UNIT_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [7:0] CFG_ADDR,
    input wire logic [7:0] CFG_WDATA,
    output logic [7:0] CFG_RDATA,
    output logic CFG_RVALID,
    input wire logic POWER_SOURCE_SELECT,
    input wire logic COMPOUND_DEVICE,
    input wire logic [3:1] PORT_POWER_REQ,
    output logic [3:1] PORT_AVAILABLE,
    output logic [3:1] PORT_POWER_GOOD,
    output logic [7:0] REPORTED_DRAW,
    output logic [8:0] REPORTED_DRAW_MA
);
    logic [2:0] dis_sp_ff;
    logic [2:0] dis_bp_ff;
    logic [7:0] max_sp_ff;
    logic [7:0] max_bp_ff;
    logic [7:0] ctl_sp_ff;
    logic [7:0] ctl_bp_ff;
    logic [7:0] pon_ff;
    logic [7:0] nxt_rdata;
    logic [31:0] pre_ff;
    logic tick_ff;
    logic [2:0] avail;
    logic [7:0] draw;
    hpc_pkg::hpc_profile_t prof_sp;
    hpc_pkg::hpc_profile_t prof_bp;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Values above 100 mA are refused by saturation, not by dropping the write
    function automatic logic [7:0] cap_draw(input logic [7:0] v);
        cap_draw = (v > `HPC_DRAW_CAP) ? `HPC_DRAW_CAP : v;
    endfunction

    // Byte layout of a port mask: bit 0 and bits 7..4 always zero
    function automatic logic [7:0] mask_byte(input logic [2:0] m);
        mask_byte = {4'h0, m, 1'b0};
    endfunction

    // Two milliamps per unit
    function automatic logic [8:0] units_to_ma(input logic [7:0] u);
        units_to_ma = {u, 1'b0};
    endfunction

    // ----------------------------------------
    // Port disable masks
    // ----------------------------------------
    // Only ports 3..1 exist, so only those bits are kept
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            dis_sp_ff <= `HPC_RST_MASK;
            dis_bp_ff <= `HPC_RST_MASK;
        end else if (CE && CFG_WR) begin
            if (CFG_ADDR == `HPC_OFS_DIS_SP) begin
                dis_sp_ff <= CFG_WDATA[`HPC_MASK_HI:`HPC_MASK_LO];
            end
            if (CFG_ADDR == `HPC_OFS_DIS_BP) begin
                dis_bp_ff <= CFG_WDATA[`HPC_MASK_HI:`HPC_MASK_LO];
            end
        end
    end

    // ----------------------------------------
    // Maximum draw bytes
    // ----------------------------------------
    // Self-powered figure is capped; bus-powered stored as written
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            max_sp_ff <= `HPC_RST_MAX;
            max_bp_ff <= `HPC_RST_MAX;
        end else if (CE && CFG_WR) begin
            if (CFG_ADDR == `HPC_OFS_MAX_SP) begin
                max_sp_ff <= cap_draw(CFG_WDATA);
            end
            if (CFG_ADDR == `HPC_OFS_MAX_BP) begin
                max_bp_ff <= CFG_WDATA;
            end
        end
    end

    // ----------------------------------------
    // Controller draw bytes
    // ----------------------------------------
    // Both default to 50 units, which is 100 mA
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            ctl_sp_ff <= `HPC_RST_CTL;
            ctl_bp_ff <= `HPC_RST_CTL;
        end else if (CE && CFG_WR) begin
            if (CFG_ADDR == `HPC_OFS_CTL_SP) begin
                ctl_sp_ff <= cap_draw(CFG_WDATA);
            end
            if (CFG_ADDR == `HPC_OFS_CTL_BP) begin
                ctl_bp_ff <= CFG_WDATA;
            end
        end
    end

    // ----------------------------------------
    // Power-on time
    // ----------------------------------------
    // New value takes effect on the next comparison, even mid sequence
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            pon_ff <= `HPC_RST_PON;
        end else if (CE && CFG_WR && CFG_ADDR == `HPC_OFS_PON) begin
            pon_ff <= CFG_WDATA;
        end
    end

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    // Unmapped offsets read zero
    always_comb begin
        case (CFG_ADDR)
            `HPC_OFS_DIS_SP: nxt_rdata = mask_byte(dis_sp_ff);
            `HPC_OFS_DIS_BP: nxt_rdata = mask_byte(dis_bp_ff);
            `HPC_OFS_MAX_SP: nxt_rdata = max_sp_ff;
            `HPC_OFS_MAX_BP: nxt_rdata = max_bp_ff;
            `HPC_OFS_CTL_SP: nxt_rdata = ctl_sp_ff;
            `HPC_OFS_CTL_BP: nxt_rdata = ctl_bp_ff;
            `HPC_OFS_PON: nxt_rdata = pon_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // Data one clock after the strobe
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            CFG_RDATA <= 8'h00;
            CFG_RVALID <= 1'b0;
        end else if (CE) begin
            CFG_RVALID <= CFG_RD;
            if (CFG_RD) begin
                CFG_RDATA <= nxt_rdata;
            end
        end
    end

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    assign prof_sp = '{disable_mask: dis_sp_ff, max_draw: max_sp_ff, controller_draw: ctl_sp_ff};
    assign prof_bp = '{disable_mask: dis_bp_ff, max_draw: max_bp_ff, controller_draw: ctl_bp_ff};

    hpc_mask_sel u_sel (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .ce(CE),
        .self_mode(POWER_SOURCE_SELECT),
        .compound(COMPOUND_DEVICE),
        .prof_sp(prof_sp),
        .prof_bp(prof_bp),
        .port_avail_ff(avail),
        .draw_ff(draw)
    );

    assign PORT_AVAILABLE = avail;
    assign REPORTED_DRAW = draw;

    // Milliamp view registered so it is a clean data output
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            REPORTED_DRAW_MA <= units_to_ma(`HPC_RST_CTL);
        end else if (CE) begin
            REPORTED_DRAW_MA <= units_to_ma(draw);
        end
    end

    // ----------------------------------------
    // 2 ms tick
    // ----------------------------------------
    // Free running and shared, so the first unit of a sequence may be short
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            pre_ff <= 32'h0;
            tick_ff <= 1'b0;
        end else if (CE) begin
            tick_ff <= (pre_ff == PON_UNIT_CYC - 1);
            if (pre_ff == PON_UNIT_CYC - 1) begin
                pre_ff <= 32'h0;
            end else begin
                pre_ff <= pre_ff + 32'h1;
            end
        end
    end

    // ----------------------------------------
    // Per-port power-good timers
    // ----------------------------------------
    for (genvar p = 1; p <= 3; p++) begin : g_port
        hpc_pgood_timer u_tmr (
            .clk(SYS_CLK),
            .rstn(RSTN),
            .ce(CE),
            .tick(tick_ff),
            .power_req(PORT_POWER_REQ[p]),
            .port_avail(avail[p-1]),
            .delay_units(pon_ff),
            .power_good(PORT_POWER_GOOD[p])
        );
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN || !CE);

    property p_sp_reserved;
        CFG_RD && CFG_ADDR == `HPC_OFS_DIS_SP ##1 CE |-> CFG_RDATA[7:4] == 4'h0 && !CFG_RDATA[0];
    endproperty
    a_sp_reserved: assert property (p_sp_reserved) else $error("reserved mask bits set");

    // The loader leaves one idle cycle between a write and the read behind it
    property p_bp_readback;
        CFG_WR && CFG_ADDR == `HPC_OFS_DIS_BP ##1 !CFG_WR ##1 CFG_RD && CFG_ADDR == `HPC_OFS_DIS_BP ##1 CE
            |-> CFG_RDATA == mask_byte($past(CFG_WDATA[3:1], 3));
    endproperty
    a_bp_readback: assert property (p_bp_readback) else $error("bus mask readback wrong");

    property p_sp_cap;
        CFG_WR && CFG_ADDR == `HPC_OFS_MAX_SP && CFG_WDATA > 8'h32 ##1 CE |-> max_sp_ff == 8'h32;
    endproperty
    a_sp_cap: assert property (p_sp_cap) else $error("self max draw above cap");

    property p_bp_store;
        CFG_WR && CFG_ADDR == `HPC_OFS_MAX_BP ##1 CE |-> max_bp_ff == $past(CFG_WDATA);
    endproperty
    a_bp_store: assert property (p_bp_store) else $error("bus max draw not stored");

    property p_ctl_sp_default;
        $rose(RSTN) |-> ctl_sp_ff == 8'h32;
    endproperty
    a_ctl_sp_default: assert property (@(posedge SYS_CLK) p_ctl_sp_default)
        else $error("self controller default wrong");

    property p_ctl_bp_default;
        $rose(RSTN) |-> ctl_bp_ff == 8'h32 && max_sp_ff <= 8'h32;
    endproperty
    a_ctl_bp_default: assert property (@(posedge SYS_CLK) p_ctl_bp_default)
        else $error("bus controller default wrong");

    property p_disabled_no_good;
        !PORT_AVAILABLE[1] |-> ##1 !PORT_POWER_GOOD[1] || !CE;
    endproperty
    a_disabled_no_good: assert property (p_disabled_no_good) else $error("disabled port powered");

    property p_ma_scale;
        ##1 CE |-> REPORTED_DRAW_MA == {$past(draw), 1'b0};
    endproperty
    a_ma_scale: assert property (p_ma_scale) else $error("draw not in 2 mA units");

    // Stored bytes checked one edge after the strobe that wrote them
    property p_sp_mask_store;
        CFG_WR && CFG_ADDR == `HPC_OFS_DIS_SP ##1 CE |-> dis_sp_ff == $past(CFG_WDATA[3:1]);
    endproperty
    a_sp_mask_store: assert property (p_sp_mask_store) else $error("self mask not stored");

    property p_bp_mask_store;
        CFG_WR && CFG_ADDR == `HPC_OFS_DIS_BP ##1 CE |-> dis_bp_ff == $past(CFG_WDATA[3:1]);
    endproperty
    a_bp_mask_store: assert property (p_bp_mask_store) else $error("bus mask not stored");

    property p_sp_read_cap;
        CFG_RD && CFG_ADDR == `HPC_OFS_MAX_SP ##1 CE |-> CFG_RDATA <= 8'h32;
    endproperty
    a_sp_read_cap: assert property (p_sp_read_cap) else $error("self max draw reads above cap");

    property p_ctl_sp_cap;
        CFG_WR && CFG_ADDR == `HPC_OFS_CTL_SP && CFG_WDATA > 8'h32 ##1 CE |-> ctl_sp_ff == 8'h32;
    endproperty
    a_ctl_sp_cap: assert property (p_ctl_sp_cap) else $error("self controller draw above cap");

    property p_ctl_sp_read_cap;
        CFG_RD && CFG_ADDR == `HPC_OFS_CTL_SP ##1 CE |-> CFG_RDATA <= 8'h32;
    endproperty
    a_ctl_sp_read_cap: assert property (p_ctl_sp_read_cap) else $error("controller draw reads above cap");

    property p_ctl_bp_store;
        CFG_WR && CFG_ADDR == `HPC_OFS_CTL_BP ##1 CE |-> ctl_bp_ff == $past(CFG_WDATA);
    endproperty
    a_ctl_bp_store: assert property (p_ctl_bp_store) else $error("bus controller draw not stored");

    property p_pon_store;
        CFG_WR && CFG_ADDR == `HPC_OFS_PON ##1 CE |-> pon_ff == $past(CFG_WDATA);
    endproperty
    a_pon_store: assert property (p_pon_store) else $error("power-on time not stored");

    // A dropped request must end power good on the very next edge
    property p_good_needs_req;
        !PORT_POWER_REQ[3] |-> ##1 !PORT_POWER_GOOD[3];
    endproperty
    a_good_needs_req: assert property (p_good_needs_req) else $error("power good without request");

    c_cap_write: cover property (CFG_WR && CFG_ADDR == `HPC_OFS_MAX_SP && CFG_WDATA > 8'h32);
    c_readback: cover property (CFG_RVALID && CFG_RDATA != 8'h00);
    c_tick: cover property (tick_ff);
endmodule

// File: hdl/hpc_consts.svh
// Offsets, field positions, reset values and timing for the hub power config bytes.
// Assumes inclusion by bare name from design files on the 50 MHz SYS_CLK domain.
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HPC_OFS_DIS_SP 8'h09
`define HPC_OFS_DIS_BP 8'h0A
`define HPC_OFS_MAX_SP 8'h0B
`define HPC_OFS_MAX_BP 8'h0C
`define HPC_OFS_CTL_SP 8'h0D
`define HPC_OFS_CTL_BP 8'h0E
`define HPC_OFS_PON 8'h0F

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define HPC_MASK_HI 3
`define HPC_MASK_LO 1
`define HPC_DRAW_CAP 8'h32
`define HPC_RST_MASK 3'h0
`define HPC_RST_MAX 8'h32
`define HPC_RST_CTL 8'h32
`define HPC_RST_PON 8'h32

// ----------------------------------------
// Timing
// ----------------------------------------
`define HPC_CLK_PERIOD_NS 20
`define HPC_PON_UNIT_NS 2000000
`define HPC_PON_UNIT_CYC (`HPC_PON_UNIT_NS / `HPC_CLK_PERIOD_NS)

`endif

// File: hdl/hpc_mask_sel.sv
// Picks the mask and draw values of the current power mode.
// Assumes same-clock inputs; outputs are registered.
`timescale 1ns/1ps
`include "hpc_consts.svh"
module hpc_mask_sel (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic self_mode,
    input wire logic compound,
    input wire hpc_pkg::hpc_profile_t prof_sp,
    input wire hpc_pkg::hpc_profile_t prof_bp,
    output logic [2:0] port_avail_ff,
    output logic [7:0] draw_ff
);
    hpc_pkg::hpc_profile_t sel;

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    // Mode picks the whole profile at once
    always_comb begin
        sel = self_mode ? prof_sp : prof_bp;
    end

    // Registered so a mode change takes effect one clock later, glitch free
    always_ff @(posedge clk) begin
        if (!rstn) begin
            port_avail_ff <= 3'h7;
            draw_ff <= `HPC_RST_CTL;
        end else if (ce) begin
            port_avail_ff <= ~sel.disable_mask;
            draw_ff <= compound ? sel.max_draw : sel.controller_draw;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || !ce);

    property p_self_mask;
        self_mode && $stable(prof_sp.disable_mask) ##1 ce |-> port_avail_ff == ~$past(prof_sp.disable_mask);
    endproperty
    a_self_mask: assert property (p_self_mask) else $error("self mask not applied");

    property p_bus_mask;
        !self_mode ##1 ce |-> port_avail_ff == ~$past(prof_bp.disable_mask);
    endproperty
    a_bus_mask: assert property (p_bus_mask) else $error("bus mask not applied");

    property p_mode_change;
        $changed(self_mode) ##1 ce |-> port_avail_ff == ~$past(sel.disable_mask);
    endproperty
    a_mode_change: assert property (p_mode_change) else $error("mask lags mode change");

    property p_compound;
        compound && self_mode ##1 ce |-> draw_ff == $past(prof_sp.max_draw);
    endproperty
    a_compound: assert property (p_compound) else $error("compound draw wrong");

    c_mode_flip: cover property ($changed(self_mode));
endmodule

// File: hdl/hpc_pgood_timer.sv
// One port's power-good delay, counted in shared 2 ms ticks.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`include "hpc_consts.svh"
module hpc_pgood_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic tick,
    input wire logic power_req,
    input wire logic port_avail,
    input wire logic [7:0] delay_units,
    output logic power_good
);
    hpc_pkg::hpc_pwr_state_t state_ff;
    hpc_pkg::hpc_pwr_state_t nxt_state;
    logic [7:0] units_ff;
    logic req_ff;

    // Next state; disabled port or dropped request aborts at once
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            hpc_pkg::HPC_PWR_IDLE: begin
                if (power_req && !req_ff && port_avail) begin
                    nxt_state = hpc_pkg::HPC_PWR_RAMP;
                end
            end
            hpc_pkg::HPC_PWR_RAMP: begin
                if (units_ff == delay_units) begin
                    nxt_state = hpc_pkg::HPC_PWR_GOOD;
                end
            end
            hpc_pkg::HPC_PWR_GOOD: nxt_state = hpc_pkg::HPC_PWR_GOOD;
            default: nxt_state = hpc_pkg::HPC_PWR_IDLE;
        endcase
        if (!power_req || !port_avail) begin
            nxt_state = hpc_pkg::HPC_PWR_IDLE;
        end
    end

    // State, request edge memory and elapsed units
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_ff <= hpc_pkg::HPC_PWR_IDLE;
            req_ff <= 1'b0;
            units_ff <= 8'h00;
        end else if (ce) begin
            state_ff <= nxt_state;
            req_ff <= power_req;
            if (state_ff != hpc_pkg::HPC_PWR_RAMP) begin
                units_ff <= 8'h00;
            end else if (tick && units_ff != delay_units) begin
                units_ff <= units_ff + 8'h01;
            end
        end
    end

    assign power_good = (state_ff == hpc_pkg::HPC_PWR_GOOD);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || !ce);

    property p_good_after_delay;
        $rose(power_good) |-> $past(units_ff) == $past(delay_units);
    endproperty
    a_good_after_delay: assert property (p_good_after_delay) else $error("power good early");

    c_good: cover property ($rose(power_good));
endmodule

// File: hdl/hpc_pkg.sv
// Types shared by the hub power config bytes and its helpers.
// Assumes the constants header supplies all numeric values.
package hpc_pkg;

    // Values that apply to one power mode
    typedef struct packed {
        logic [2:0] disable_mask;
        logic [7:0] max_draw;
        logic [7:0] controller_draw;
    } hpc_profile_t;

    // Per-port power-good sequencing
    typedef enum logic [2:0] {
        HPC_PWR_IDLE = 3'h1,
        HPC_PWR_RAMP = 3'h2,
        HPC_PWR_GOOD = 3'h4
    } hpc_pwr_state_t;

endpackage

// File: test/hpc_loader_model.sv
// Loader model: stands in for the config memory or management host writing bytes.
// Assumes one SYS_CLK domain; callers run its tasks from the bench's main sequence.
`timescale 1ns/1ps
module hpc_loader_model (
    input wire logic clk,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    // ----------------------------------------
    // Idle state
    // ----------------------------------------
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
    end

    // Address and data flip once released, so stale values never look valid
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_addr <= ~a;
        cfg_wdata <= ~d;
    endtask

    // Answer is a one-cycle pulse, so it is sampled in the cycle after the taking edge
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        cfg_addr <= ~a;
        #1;
        ok = cfg_rvalid;
        d = cfg_rdata;
    endtask
endmodule

// File: test/hub_power_port_config_bytes_test.sv
// Bench for the hub power config bytes: registers, mode selection, power-good delay.
// Assumes the loader model drives the byte port; PON_UNIT_CYC shortened to 10.
`timescale 1ns/1ps
module hub_power_port_config_bytes_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic sel = 1'b0;
    logic comp = 1'b0;
    logic [3:1] req = 3'h0;
    logic cfg_wr, cfg_rd, rvalid;
    logic [7:0] addr, wdata, rdata, draw;
    logic [8:0] draw_ma;
    logic [3:1] avail, good;
    int fails = 0;
    int compares = 0;

    // ----------------------------------------
    // Clock, design and loader
    // ----------------------------------------
    always #10 sys_clk = ~sys_clk;

    hpc_config_bytes #(.PON_UNIT_CYC(10)) dut (
        .SYS_CLK(sys_clk), .RSTN(rstn), .CE(ce), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd),
        .CFG_ADDR(addr), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_RVALID(rvalid),
        .POWER_SOURCE_SELECT(sel), .COMPOUND_DEVICE(comp), .PORT_POWER_REQ(req),
        .PORT_AVAILABLE(avail), .PORT_POWER_GOOD(good), .REPORTED_DRAW(draw),
        .REPORTED_DRAW_MA(draw_ma)
    );

    hpc_loader_model ld (
        .clk(sys_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(addr),
        .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_rvalid(rvalid)
    );

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic end_sim();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        ld.read_byte(a, d, ok);
        check({8'h00, ok}, 9'h001);
        check({1'b0, d}, {1'b0, exp});
    endtask

    // Mode inputs settle through the select stage before they are judged
    task automatic set_mode(input logic s, input logic c);
        @(posedge sys_clk);
        sel <= s;
        comp <= c;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic pg_wait(input int p, output int n);
        @(posedge sys_clk);
        req[p] <= 1'b1;
        n = 0;
        while (n < 100 && good[p] !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        check({6'h00, avail}, 9'h007);
        check({1'b0, draw}, 9'h032);
        check(draw_ma, 9'h064);
        rd_chk(8'h09, 8'h00);
        rd_chk(8'h0A, 8'h00);
        rd_chk(8'h0D, 8'h32);
        rd_chk(8'h0E, 8'h32);
    endtask

    // Reserved mask bits and bit 0 must never read back; unmapped places stay empty
    task automatic t_masks();
        ld.write_byte(8'h09, 8'hFF);
        ld.write_byte(8'h0A, 8'hF5);
        ld.write_byte(8'h10, 8'hAA);
        rd_chk(8'h09, 8'h0E);
        rd_chk(8'h0A, 8'h04);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h08, 8'h00);
    endtask

    task automatic t_caps();
        ld.write_byte(8'h0B, 8'h40);
        ld.write_byte(8'h0C, 8'h40);
        ld.write_byte(8'h0D, 8'hFF);
        ld.write_byte(8'h0E, 8'h64);
        rd_chk(8'h0B, 8'h32);
        rd_chk(8'h0C, 8'h40);
        rd_chk(8'h0D, 8'h32);
        rd_chk(8'h0E, 8'h64);
    endtask

    task automatic t_modes();
        ld.write_byte(8'h09, 8'h06);
        ld.write_byte(8'h0A, 8'h08);
        rd_chk(8'h0A, 8'h08);
        set_mode(1'b1, 1'b0);
        check({6'h00, avail}, 9'h004);
        set_mode(1'b0, 1'b0);
        check({6'h00, avail}, 9'h003);
    endtask

    // Every pairing of power source and compound flag picks its own byte
    task automatic t_draw();
        logic [7:0] exp;
        ld.write_byte(8'h0D, 8'h20);
        for (int i = 0; i < 4; i++) begin
            exp = i[1] ? (i[0] ? 8'h32 : 8'h20) : (i[0] ? 8'h40 : 8'h64);
            set_mode(i[1], i[0]);
            check({1'b0, draw}, {1'b0, exp});
            check(draw_ma, {exp, 1'b0});
        end
    endtask

    task automatic t_pgood();
        int n;
        ld.write_byte(8'h09, 8'h00);
        ld.write_byte(8'h0F, 8'h00);
        set_mode(1'b1, 1'b0);
        pg_wait(3, n);
        check(n[8:0], 9'h002);
        ld.write_byte(8'h0F, 8'h03);
        pg_wait(1, n);
        check({8'h00, n >= 22 && n <= 32}, 9'h001);
        // Disabling a powered port must drop its power good
        ld.write_byte(8'h09, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1;
        check({8'h00, good[1]}, 9'h000);
        check({8'h00, good[3]}, 9'h001);
        @(posedge sys_clk);
        req <= 3'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({6'h00, good}, 9'h000);
        // A refused request is not remembered once the port comes back
        ld.write_byte(8'h09, 8'h04);
        pg_wait(2, n);
        check({6'h00, good}, 9'h000);
        ld.write_byte(8'h09, 8'h00);
        repeat (40) @(posedge sys_clk);
        #1;
        check({6'h00, avail}, 9'h007);
        check({6'h00, good}, 9'h000);
        @(posedge sys_clk);
        req <= 3'h0;
    endtask

    // Clock enable low must drop a write on the floor
    task automatic t_ce();
        @(posedge sys_clk);
        ce <= 1'b0;
        ld.write_byte(8'h0F, 8'h11);
        @(posedge sys_clk);
        ce <= 1'b1;
        rd_chk(8'h0F, 8'h03);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_masks();
        t_caps();
        t_modes();
        t_draw();
        t_pgood();
        t_ce();
        end_sim();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        end_sim();
    end
endmodule
